// file: verification/pin_control_properties.sv
`timescale 1ns/1ps
module pin_control_properties (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic reset_low,
  input wire logic external_event_in,
  input wire logic service_boot_in_low,
  input wire logic time_pulse_out,
  input wire logic amp_enable_out,
  input wire logic antenna_good,
  input wire logic txd_out
);
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (reset);

  // internal reset lands three edges after the pin falls, so five low samples is safe
  sequence held_low;
    !reset_low [*5];
  endsequence
  sequence released;
    held_low ##1 reset_low;
  endsequence

  tp_reset_a: assert property (held_low |-> !time_pulse_out)
    else $error("time pulse active in reset");
  amp_reset_a: assert property (held_low |-> !amp_enable_out)
    else $error("amplifier enabled in reset");
  ant_reset_a: assert property (held_low |-> antenna_good)
    else $error("antenna status wrong in reset");
  txd_reset_a: assert property (held_low |-> txd_out)
    else $error("transmit pin not idle in reset");
  release_quiet_a: assert property (released |-> !time_pulse_out ##1 !time_pulse_out)
    else $error("time pulse before synchronised release");
  pulse_start_a: assert property (released |-> ##[2:6] time_pulse_out)
    else $error("time pulse late after release");
  // a pin reset may cut a pulse short, so it also disables this check
  pulse_width_a: assert property (disable iff (reset || !reset_low)
    $rose(time_pulse_out) |-> time_pulse_out [*5])
    else $error("time pulse too short");
  boot_idle_a: assert property (service_boot_in_low)
    else $error("service input driven");
  host_hold_a: assert property ($fell(reset_low) |-> !reset_low [*8] ##[1:2] reset_low)
    else $error("reset pin not a bounded pulse");
endmodule

// file: verification/test_gnss_module_pin_control.sv
`timescale 1ns/1ps
module test_gnss_module_pin_control;
  import pin_control_pkg::*;
  logic        ref_clk, reset, io_supply_ok, psm_active, psm_cycle_on, event_wake_en;
  logic        event_power_en, event_force_off_en, time_aid_en, freq_aid_en, open_det_en;
  logic        antenna_fault, serial_tx_data, txp_en, txp_active_high, reset_request;
  logic        event_level, aid_en, use_antenna_detect, antenna_present_in;
  logic [31:0] freq_nominal, pulse_period, freq_period;
  logic [15:0] txp_threshold, tx_level;
  logic        system_reset_out, receiver_on, wake_pulse, time_sync_pulse, freq_valid;
  logic        freq_fast, antenna_open, service_boot_req, module_in_reset;
  logic        time_pulse_seen, amp_on, antenna_ok, tx_pending, r0;
  int          num_errors, compares, wakes, syncs, tps, n0;

  pin_bus pins ();
  pin_control_device #(.PULSE_PERIOD(20), .PULSE_WIDTH(5)) pin_control_device_i (
    .ref_clk, .reset, .pins, .io_supply_ok, .psm_active, .psm_cycle_on, .event_wake_en,
    .event_power_en, .event_force_off_en, .time_aid_en, .freq_aid_en, .freq_nominal,
    .open_det_en, .antenna_fault, .pulse_period, .serial_tx_data, .txp_en,
    .txp_active_high, .txp_threshold, .tx_level, .system_reset_out, .receiver_on,
    .wake_pulse, .time_sync_pulse, .freq_valid, .freq_period, .freq_fast, .antenna_open,
    .service_boot_req);
  pin_control_host pin_control_host_i (
    .ref_clk, .reset, .pins, .reset_request, .event_level, .aid_en, .use_antenna_detect,
    .antenna_present_in, .txp_active_high, .module_in_reset, .time_pulse_seen, .amp_on,
    .antenna_ok, .tx_pending);
  pin_control_properties pin_control_properties_i (
    .ref_clk, .reset, .reset_low(pins.reset_low), .external_event_in(pins.external_event_in),
    .service_boot_in_low(pins.service_boot_in_low), .time_pulse_out(pins.time_pulse_out),
    .amp_enable_out(pins.amp_enable_out), .antenna_good(pins.antenna_good),
    .txd_out(pins.txd_out));

  always @(posedge ref_clk) begin
    wakes <= wakes + int'(wake_pulse === 1'b1);
    syncs <= syncs + int'(time_sync_pulse === 1'b1);
    tps <= tps + int'(time_pulse_seen === 1'b1);
  end

  task automatic complete_run();
    $display("comparisons %0d, mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic check(input logic ok, input string what);
    compares++;
    if (ok !== 1'b1) begin
      num_errors++;
      $display("BAD %0t: %s", $time, what);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask

  // every wait is bounded; running out ends the run
  task automatic wait_on(ref logic s, input logic v, input string what);
    int n;
    for (n = 0; n < 300 && s !== v; n++)
      @(negedge ref_clk);
    check(s === v, what);
    if (s !== v)
      complete_run();
  endtask

  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  initial begin
    {reset, io_supply_ok, serial_tx_data} = 3'h7;
    {psm_active, psm_cycle_on, event_wake_en, event_power_en, event_force_off_en} = 5'h00;
    {time_aid_en, freq_aid_en, open_det_en, antenna_fault, txp_en} = 5'h00;
    {txp_active_high, reset_request, event_level, aid_en} = 4'h0;
    {use_antenna_detect, antenna_present_in} = 2'h0;
    {freq_nominal, pulse_period, txp_threshold, tx_level} = '0;
    {num_errors, compares} = '0;
    cyc(4);
    reset = 1'b0;
    wait_on(system_reset_out, 1'b0, "reset release");
    check(antenna_open === 1'b0, "open detection on at reset");
    event_level = 1'b1;
    cyc(8);
    event_level = 1'b0;
    cyc(8);
    check(wakes == 0 && syncs == 0 && receiver_on === 1'b1, "event acted");
    $display("idle test done");
    n0 = tps;
    cyc(100);
    check(tps == n0 + 5, "default pulse rate");
    pulse_period = 32'h0000_0028;
    cyc(40);
    n0 = tps;
    cyc(120);
    check(tps == n0 + 3, "configured pulse rate");
    pulse_period = 32'h0000_0000;
    $display("pulse test done");
    reset_request = 1'b1;
    cyc(1);
    reset_request = 1'b0;
    wait_on(system_reset_out, 1'b1, "pin reset");
    check(module_in_reset === 1'b1, "host reset flag not shown");
    wait_on(system_reset_out, 1'b0, "pin reset end");
    check(module_in_reset === 1'b0, "host reset pulse not bounded");
    wait_on(time_pulse_seen, 1'b1, "pulse after reset");
    cyc(6);
    io_supply_ok = 1'b0;
    wait_on(system_reset_out, 1'b1, "supply reset");
    cyc(10);
    check(system_reset_out === 1'b1, "supply reset held");
    io_supply_ok = 1'b1;
    wait_on(system_reset_out, 1'b0, "supply back");
    $display("reset test done");
    psm_active = 1'b1;
    cyc(8);
    check(receiver_on === 1'b0 && amp_on === 1'b0, "amplifier on while idle");
    event_wake_en = 1'b1;
    n0 = wakes;
    event_level = 1'b1;
    cyc(8);
    check(wakes == n0 + 1, "wake count");
    {event_level, event_wake_en, psm_cycle_on} = 3'h1;
    cyc(8);
    check(receiver_on === 1'b1 && amp_on === 1'b1, "amplifier off while on");
    {psm_cycle_on, event_power_en} = 2'h1;
    cyc(8);
    check(receiver_on === 1'b0, "power control low");
    event_level = 1'b1;
    cyc(8);
    check(receiver_on === 1'b1 && amp_on === 1'b1, "power control high");
    {event_level, event_power_en, psm_active, event_force_off_en} = 4'h1;
    cyc(8);
    r0 = receiver_on;
    event_level = 1'b1;
    cyc(8);
    check(r0 === 1'b0 && receiver_on === 1'b1, "force off ignored");
    {event_level, event_force_off_en, time_aid_en} = 3'h1;
    cyc(8);
    n0 = syncs;
    event_level = 1'b1;
    cyc(8);
    check(syncs == n0 + 1, "time sync count");
    {event_level, time_aid_en} = 2'h0;
    $display("event test done");
    {freq_aid_en, aid_en} = 2'h3;
    freq_nominal = 32'h0000_0032;
    wait_on(freq_valid, 1'b1, "frequency measure");
    check(freq_period === 32'h0000_0028 && freq_fast === 1'b1, "fast aid");
    freq_nominal = 32'h0000_001E;
    cyc(1);
    wait_on(freq_valid, 1'b1, "frequency measure");
    check(freq_period === 32'h0000_0028 && freq_fast === 1'b0, "slow aid");
    {freq_aid_en, aid_en, antenna_fault} = 3'h1;
    cyc(5);
    check(antenna_ok === 1'b0, "short not shown");
    {antenna_fault, open_det_en, use_antenna_detect, antenna_present_in} = 4'h7;
    cyc(6);
    check(antenna_ok === 1'b1 && antenna_open === 1'b0, "antenna present");
    antenna_present_in = 1'b0;
    cyc(6);
    check(antenna_open === 1'b1, "open not shown");
    {open_det_en, use_antenna_detect, serial_tx_data} = 3'h0;
    $display("aid and antenna test done");
    cyc(3);
    check(pins.txd_out === 1'b0, "serial data not passed");
    {serial_tx_data, txp_en} = 2'h3;
    for (int p = 0; p < 2; p++) begin
      {txp_active_high, txp_threshold, tx_level} = {1'(p), 16'h0004, 16'h0003};
      cyc(4);
      check(tx_pending === 1'b0, "pending below level");
      tx_level = 16'h0004;
      cyc(4);
      check(tx_pending === 1'b1 && pins.txd_out === 1'(p), "pending flag");
    end
    check(service_boot_req === 1'b0, "service input seen");
    $display("transmit test done");
    complete_run();
  end
endmodule

// file: verilog/pin_bus.sv
`timescale 1ns/1ps
interface pin_bus;
  logic reset_low;
  logic external_event_in;
  logic service_boot_in_low;
  logic time_pulse_out;
  logic amp_enable_out;
  logic antenna_good;
  logic txd_out;

  modport device (
    input  reset_low,
    input  external_event_in,
    input  service_boot_in_low,
    output time_pulse_out,
    output amp_enable_out,
    output antenna_good,
    output txd_out
  );

  modport host (
    output reset_low,
    output external_event_in,
    output service_boot_in_low,
    input  time_pulse_out,
    input  amp_enable_out,
    input  antenna_good,
    input  txd_out
  );
endinterface

// file: verilog/pin_control_device.sv
// What this block does
// RL1: low reset pin holds whole device reset
// RL2: host pulses reset only, never power control
// RL3: event pin wakes receiver in power save
// RL4: all event functions off until enabled
// RL5: power control: event level sets receiver state
// RL6: event pin forces receiver off outside power save
// RL7: time aiding: event edge resynchronises internal time
// RL8: aiding signal max 500 kHz, phases 50 ns
// RL9: host supplies nominal aiding frequency by configuration
// RL10: time pulse one per second after reset
// RL11: amplifier enable follows receiver active state
// RL12: antenna good high, low on fault
// RL13: open detection off at reset, uses line 13
// RL14: presence input high when antenna draws current
// RL15: serial transmit pin may show transmit pending
// RL16: host leaves service boot input unconnected
// RL17: pending flag: polarity, threshold, off by default
// RL18: device held in reset without io supply
// RL19: reset, event, presence inputs pass two flops
`timescale 1ns/1ps
module pin_control_device
  import pin_control_pkg::*;
#(
  parameter int unsigned PULSE_PERIOD = pin_control_pkg::PULSE_PERIOD_CYCLES,
  parameter int unsigned PULSE_WIDTH  = pin_control_pkg::PULSE_WIDTH_CYCLES,
  parameter int unsigned CNT_W        = pin_control_pkg::COUNT_W,
  parameter int unsigned LVL_W        = pin_control_pkg::LEVEL_W
) (
  input  wire logic             ref_clk,
  input  wire logic             reset,
  pin_bus.device                pins,
  input  wire logic             io_supply_ok,
  input  wire logic             psm_active,
  input  wire logic             psm_cycle_on,
  input  wire logic             event_wake_en,
  input  wire logic             event_power_en,
  input  wire logic             event_force_off_en,
  input  wire logic             time_aid_en,
  input  wire logic             freq_aid_en,
  input  wire logic [CNT_W-1:0] freq_nominal,
  input  wire logic             open_det_en,
  input  wire logic             antenna_fault,
  input  wire logic [CNT_W-1:0] pulse_period,
  input  wire logic             serial_tx_data,
  input  wire logic             txp_en,
  input  wire logic             txp_active_high,
  input  wire logic [LVL_W-1:0] txp_threshold,
  input  wire logic [LVL_W-1:0] tx_level,
  output logic                  system_reset_out,
  output logic                  receiver_on,
  output logic                  wake_pulse,
  output logic                  time_sync_pulse,
  output logic                  freq_valid,
  output logic [CNT_W-1:0]      freq_period,
  output logic                  freq_fast,
  output logic                  antenna_open,
  output logic                  service_boot_req
);
  import pin_control_pkg::*;

  initial begin
    if (PULSE_PERIOD < 2 || PULSE_WIDTH < 1 || PULSE_WIDTH >= PULSE_PERIOD) begin
      $error("pin_control_device: time pulse width must be within the period");
    end
    if (CNT_W < 8 || CNT_W > 32 || LVL_W < 1) begin
      $error("pin_control_device: counter widths out of range");
    end
  end

  // saturating increment, used by both counters
  function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] v);
    sat_inc = (&v) ? v : v + 1'b1;
  endfunction

  // two-flop synchronisers for every pin-side input
  logic [SYNC_W-1:0] sync1_reg;
  logic [SYNC_W-1:0] sync2_reg;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      sync1_reg <= 4'hF;
      sync2_reg <= 4'hF;
    end else begin
      sync1_reg[SYNC_RESET_BIT]  <= pins.reset_low;          // [RL19]
      sync1_reg[SYNC_EVENT_BIT]  <= pins.external_event_in;  // [RL19]
      sync1_reg[SYNC_SUPPLY_BIT] <= io_supply_ok;
      sync1_reg[SYNC_BOOT_BIT]   <= pins.service_boot_in_low;
      sync2_reg                  <= sync1_reg;
    end
  end

  wire reset_low_s   = sync2_reg[SYNC_RESET_BIT];
  wire event_s       = sync2_reg[SYNC_EVENT_BIT];
  wire supply_s      = sync2_reg[SYNC_SUPPLY_BIT];
  wire boot_low_s    = sync2_reg[SYNC_BOOT_BIT];

  // whole-system reset: pin low or io supply missing
  wire sys_rst_next  = reset | ~reset_low_s | ~supply_s;  // [RL1] [RL18]
  logic sys_rst_reg;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      sys_rst_reg <= 1'b1;
    end else begin
      sys_rst_reg <= sys_rst_next;
    end
  end

  // event edge detection; the line belongs to open detection when that is on
  logic event_prev_reg;
  wire  event_owned  = ~open_det_en;                               // [RL13]
  wire  event_rise   = event_owned & event_s & ~event_prev_reg;

  always_ff @(posedge ref_clk) begin
    if (sys_rst_reg) begin
      event_prev_reg <= 1'b1;
    end else begin
      event_prev_reg <= event_s;
    end
  end

  // receiver power state
  wire wake_hit      = psm_active & event_wake_en & event_owned & event_rise;      // [RL3] [RL4]
  wire power_ctl     = event_power_en & event_owned;                                // [RL4]
  wire force_off     = ~psm_active & event_force_off_en & event_owned & ~event_s;  // [RL6]
  wire psm_state     = psm_cycle_on | wake_hit;
  wire base_state    = psm_active ? psm_state : ~force_off;
  wire rx_on_next    = power_ctl ? event_s : base_state;                            // [RL5]

  logic rx_on_reg;
  logic wake_reg;
  logic amp_reg;

  always_ff @(posedge ref_clk) begin
    if (sys_rst_reg) begin
      rx_on_reg <= 1'b0;
      wake_reg  <= 1'b0;
      amp_reg   <= 1'b0;
    end else begin
      rx_on_reg <= rx_on_next;
      wake_reg  <= wake_hit;
      amp_reg   <= rx_on_next;  // [RL11]
    end
  end

  // time pulse; a zero period request keeps the one-second default
  wire              time_aid_hit = time_aid_en & event_owned & event_rise;  // [RL7] [RL4]
  wire [CNT_W-1:0]  period_sel   = (pulse_period == '0) ? CNT_W'(PULSE_PERIOD) : pulse_period;
  logic [CNT_W-1:0] tp_cnt_reg;
  wire              tp_wrap      = (tp_cnt_reg >= period_sel - 1'b1);
  wire [CNT_W-1:0]  tp_cnt_next  = (time_aid_hit | tp_wrap) ? '0 : sat_inc(tp_cnt_reg);
  wire              tp_high_next = (tp_cnt_next < CNT_W'(PULSE_WIDTH));
  logic             tp_out_reg;
  logic             tsync_reg;

  always_ff @(posedge ref_clk) begin
    if (sys_rst_reg) begin
      // all ones wraps at once, so the first pulse after reset has full width
      tp_cnt_reg <= '1;      // [RL10]
      tp_out_reg <= 1'b0;
      tsync_reg  <= 1'b0;
    end else begin
      tp_cnt_reg <= tp_cnt_next;
      tp_out_reg <= tp_high_next;  // [RL10]
      tsync_reg  <= time_aid_hit;
    end
  end

  // frequency aiding: clock cycles between rising edges, compared to nominal
  // a measured period below nominal means the applied signal runs fast
  wire              freq_hit = freq_aid_en & event_owned & event_rise;  // [RL4]
  logic [CNT_W-1:0] fcnt_reg;
  logic [CNT_W-1:0] fper_reg;
  logic             fvalid_reg;
  logic             ffast_reg;
  logic             fseen_reg;
  wire [CNT_W-1:0]  fper_meas = sat_inc(fcnt_reg);

  always_ff @(posedge ref_clk) begin
    if (sys_rst_reg || !freq_aid_en) begin
      fcnt_reg   <= '0;
      fper_reg   <= '0;
      fvalid_reg <= 1'b0;
      ffast_reg  <= 1'b0;
      fseen_reg  <= 1'b0;
    end else if (freq_hit) begin
      fcnt_reg   <= '0;
      fseen_reg  <= 1'b1;
      // the first edge only opens the measurement window
      fvalid_reg <= fseen_reg;
      if (fseen_reg) begin
        fper_reg  <= fper_meas;
        ffast_reg <= (fper_meas < freq_nominal);  // [RL9]
      end
    end else begin
      fcnt_reg   <= sat_inc(fcnt_reg);
      fvalid_reg <= 1'b0;
    end
  end

  // antenna status
  logic ant_good_reg;
  logic ant_open_reg;

  always_ff @(posedge ref_clk) begin
    if (sys_rst_reg) begin
      ant_good_reg <= 1'b1;
      ant_open_reg <= 1'b0;  // [RL13]
    end else begin
      ant_good_reg <= ~antenna_fault;             // [RL12]
      ant_open_reg <= open_det_en & ~event_s;     // [RL13] [RL14]
    end
  end

  // transmit pin: serial data or transmit-pending flag
  wire  txp_level = (tx_level >= txp_threshold) && (txp_threshold != '0);
  wire  txp_pin   = txp_active_high ? txp_level : ~txp_level;                  // [RL17]
  wire  txd_next  = txp_en ? txp_pin : serial_tx_data;                          // [RL15]
  logic txd_reg;
  logic boot_reg;

  always_ff @(posedge ref_clk) begin
    if (sys_rst_reg) begin
      txd_reg  <= 1'b1;
      boot_reg <= 1'b0;
    end else begin
      txd_reg  <= txd_next;
      // the service input is only reported, it steers nothing here
      boot_reg <= ~boot_low_s;
    end
  end

  assign pins.time_pulse_out = tp_out_reg;
  assign pins.amp_enable_out = amp_reg;
  assign pins.antenna_good   = ant_good_reg;
  assign pins.txd_out        = txd_reg;

  assign system_reset_out = sys_rst_reg;
  assign receiver_on      = rx_on_reg;
  assign wake_pulse       = wake_reg;
  assign time_sync_pulse  = tsync_reg;
  assign freq_valid       = fvalid_reg;
  assign freq_period      = fper_reg;
  assign freq_fast        = ffast_reg;
  assign antenna_open     = ant_open_reg;
  assign service_boot_req = boot_reg;

endmodule

// file: verilog/pin_control_host.sv
`timescale 1ns/1ps
module pin_control_host
  import pin_control_pkg::*;
#(
  parameter int unsigned RESET_HOLD = pin_control_pkg::RESET_HOLD_CYCLES,
  parameter int unsigned AID_HALF   = pin_control_pkg::AID_MIN_PERIOD_CYC / 2
) (
  input  wire logic ref_clk,
  input  wire logic reset,
  pin_bus.host      pins,
  input  wire logic reset_request,
  input  wire logic event_level,
  input  wire logic aid_en,
  input  wire logic use_antenna_detect,
  input  wire logic antenna_present_in,
  input  wire logic txp_active_high,
  output logic      module_in_reset,
  output logic      time_pulse_seen,
  output logic      amp_on,
  output logic      antenna_ok,
  output logic      tx_pending
);
  import pin_control_pkg::*;

  initial begin
    if (AID_HALF < AID_MIN_PHASE_CYC || 2 * AID_HALF < AID_MIN_PERIOD_CYC) begin
      $error("pin_control_host: aiding signal faster than allowed");  // [RL8]
    end
    if (RESET_HOLD < 1 || RESET_HOLD > 65535) begin
      $error("pin_control_host: reset hold out of range");
    end
  end

  // reset pin driven low for a fixed burst only, never held as power control
  logic [15:0] rst_cnt_reg;
  logic        rst_low_reg;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rst_cnt_reg <= 16'h0000;
      rst_low_reg <= 1'b1;
    end else if (reset_request && rst_cnt_reg == 16'h0000) begin
      rst_cnt_reg <= 16'(RESET_HOLD);  // [RL2]
      rst_low_reg <= 1'b0;
    end else if (rst_cnt_reg != 16'h0000) begin
      rst_cnt_reg <= rst_cnt_reg - 16'h0001;
      rst_low_reg <= (rst_cnt_reg == 16'h0001);
    end
  end

  // aiding square wave, half period at least the legal phase length
  logic [15:0] aid_cnt_reg;
  logic        aid_reg;

  always_ff @(posedge ref_clk) begin
    if (reset || !aid_en) begin
      aid_cnt_reg <= 16'h0000;
      aid_reg     <= 1'b0;
    end else if (aid_cnt_reg == 16'(AID_HALF - 1)) begin
      aid_cnt_reg <= 16'h0000;
      aid_reg     <= ~aid_reg;  // [RL8]
    end else begin
      aid_cnt_reg <= aid_cnt_reg + 16'h0001;
    end
  end

  // line 13 carries either the event source or the presence detector
  wire  ev_src   = aid_en ? aid_reg : event_level;
  wire  pin_next = use_antenna_detect ? antenna_present_in : ev_src;  // [RL14]
  logic ev_reg;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ev_reg <= 1'b0;
    end else begin
      ev_reg <= pin_next;
    end
  end

  // module outputs come from another logic block, synchronise them
  logic [3:0] s1_reg;
  logic [3:0] s2_reg;
  logic       tp_prev_reg;
  logic       tp_seen_reg;
  logic       txp_reg;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      s1_reg      <= 4'h0;
      s2_reg      <= 4'h0;
      tp_prev_reg <= 1'b0;
      tp_seen_reg <= 1'b0;
      txp_reg     <= 1'b0;
    end else begin
      s1_reg      <= {pins.txd_out, pins.antenna_good, pins.amp_enable_out,
                      pins.time_pulse_out};
      s2_reg      <= s1_reg;
      tp_prev_reg <= s2_reg[0];
      tp_seen_reg <= s2_reg[0] & ~tp_prev_reg;
      txp_reg     <= txp_active_high ? s2_reg[3] : ~s2_reg[3];
    end
  end

  assign pins.reset_low           = rst_low_reg;
  assign pins.external_event_in   = ev_reg;
  // left floating on a board; modelled as its idle high level
  assign pins.service_boot_in_low = 1'b1;  // [RL16]

  assign module_in_reset = ~rst_low_reg;
  assign time_pulse_seen = tp_seen_reg;
  assign amp_on          = s2_reg[1];
  assign antenna_ok      = s2_reg[2];
  assign tx_pending      = txp_reg;

endmodule

// file: verilog/pin_control_pkg.sv
package pin_control_pkg;

  localparam int unsigned CLK_HZ            = 20_000_000;
  localparam int unsigned CLK_PERIOD_NS     = 50;

  // time pulse: one per second out of reset, high for a fixed slice of the period
  localparam int unsigned PULSE_PERIOD_S      = 1;
  localparam int unsigned PULSE_PERIOD_CYCLES = PULSE_PERIOD_S * CLK_HZ;
  localparam int unsigned PULSE_WIDTH_US      = 100;
  localparam int unsigned PULSE_WIDTH_CYCLES  = (PULSE_WIDTH_US * (CLK_HZ / 1_000_000));

  // frequency aiding limits on the event input
  localparam int unsigned AID_MAX_HZ          = 500_000;
  localparam int unsigned AID_MIN_PERIOD_CYC  = (CLK_HZ + AID_MAX_HZ - 1) / AID_MAX_HZ;
  localparam int unsigned AID_MIN_PHASE_NS    = 50;
  localparam int unsigned AID_MIN_PHASE_CYC   =
    (AID_MIN_PHASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam int unsigned RESET_HOLD_CYCLES   = 8;
  localparam int unsigned SYNC_STAGES         = 2;
  localparam int unsigned COUNT_W             = 32;
  localparam int unsigned LEVEL_W             = 16;

  // sync vector bit positions in the device
  localparam int unsigned SYNC_RESET_BIT  = 0;
  localparam int unsigned SYNC_EVENT_BIT  = 1;
  localparam int unsigned SYNC_SUPPLY_BIT = 2;
  localparam int unsigned SYNC_BOOT_BIT   = 3;
  localparam int unsigned SYNC_W          = 4;

endpackage
